// ---- rtl/antenna_diag_pkg.sv ----
// Constants for the antenna current select, driver timing and fault diagnosis logic.
// Assumes one 50 MHz system clock taken from the oscillator and a synchronous reset.
// What this block does
// - A 4-bit current step register gives sixteen antenna current levels.
// - Step value is binary, zero is step 1, all-ones is step 16 and reset default.
// - Drive pulse/pause in eighths: 1.25, 1.75, 2.5, 4 per group of four steps.
// - Antenna drive square wave runs at the oscillator clock divided by 64.
// - Each boost period the charge switch turns off when current exceeds reference.
// - A debounced power-stage fault stops all stages, latches status, clears LF buffer.
// - Command 9 from the host returns the latched diagnosis byte.
// - Power stages stay off after a fault until the host sends command 2.
// - Overtemperature shuts down only if still present when debounce ends.
// - Driver transistor overcurrent limits current at once, then shuts down if persistent.
// - Fast-start switch overcurrent is debounced and then shuts down.
// - Missing polarity changes at the sense input while driving means open load.
// - Illegal commands flag at once, without shutdown or buffer clear.
// - Open load and short to ground are checked only while the driver is active.
// - In standby the low-side and fast-start switch faults stay monitored.
// - In power-down no fault is monitored.
// - A condition gone before debounce ends is dropped with no shutdown.
// - Status bit 0 overtemperature, bit 1 short to ground, bit 2 short to supply.
// - Status bit 3 open load, bit 4 return-line overcurrent, bit 5 illegal command.
// - Fast-start gate drive stays off in power-down and after a fault shutdown.
package antenna_diag_pkg;
    localparam int CLOCK_HZ          = 50_000_000;
    localparam int DRIVE_DIVIDER     = 64;
    localparam int EIGHTH_CYCLES     = DRIVE_DIVIDER / 8;
    // High time in quarter-eighths (1.25 -> 5, 1.75 -> 7, 2.5 -> 10, 4 -> 16)
    localparam int HIGH_Q_GROUP0     = 5;
    localparam int HIGH_Q_GROUP1     = 7;
    localparam int HIGH_Q_GROUP2     = 10;
    localparam int HIGH_Q_GROUP3     = 16;
    localparam int STEP_W            = 4;
    localparam logic [3:0] STEP_DEFAULT = 4'hF;
    localparam int DEBOUNCE_TIME_NS  = 20_000;
    localparam int DEBOUNCE_CYCLES   = DEBOUNCE_TIME_NS / (1_000_000_000 / CLOCK_HZ);
    localparam int BOOST_PERIOD      = 50;
    localparam int OPEN_LOAD_WINDOW  = 128;
    localparam logic [3:0] CMD_CLEAR_STATUS = 4'h2;
    localparam logic [3:0] CMD_READ_STATUS  = 4'h9;
    localparam int BIT_TEMP          = 0;
    localparam int BIT_GND           = 1;
    localparam int BIT_SUPPLY        = 2;
    localparam int BIT_OPEN          = 3;
    localparam int BIT_RETURN        = 4;
    localparam int BIT_BADCMD        = 5;
    localparam int FLAG_W            = 6;
    localparam int STATUS_W          = 8;

    typedef enum logic [3:0] {
        ST_OFF      = 4'b0001,
        ST_STANDBY  = 4'b0010,
        ST_ACTIVE   = 4'b0100,
        ST_SHUTDOWN = 4'b1000
    } op_state_e;
endpackage : antenna_diag_pkg

// ---- rtl/fault_debounce.sv ----
// Debounce timer for one fault condition.
// Assumes condition is already synchronised to clock.
module fault_debounce #(
    parameter int CYCLES = antenna_diag_pkg::DEBOUNCE_CYCLES
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Condition in, expiry out
    input  wire logic enable,
    input  wire logic condition,
    output logic      expired
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES);

    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    logic          expired_r;
    logic          expired_nxt;

    always_comb
    begin
        count_nxt   = count_r;
        expired_nxt = 1'b0;
        if (!(enable && condition))
        begin
            count_nxt = '0;
        end
        else if (count_r != LAST)
        begin
            count_nxt = count_r + CW'(1);
        end
        expired_nxt = enable && condition && (count_nxt == LAST);
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            count_r   <= '0;
            expired_r <= 1'b0;
        end
        else
        begin
            count_r   <= count_nxt;
            expired_r <= expired_nxt;
        end
    end

    assign expired = expired_r;
endmodule : fault_debounce

// ---- rtl/antenna_fault_diag_current_select.sv ----
// Antenna driver timing, boost switch-off, fault debounce and diagnosis status.
// Analog comparator flags are asynchronous and get two flops; mode and command
// strobes come from logic on the same clock.
module antenna_fault_diag_current_select #(
    parameter int DEBOUNCE = antenna_diag_pkg::DEBOUNCE_CYCLES,
    parameter int OPEN_WIN = antenna_diag_pkg::OPEN_LOAD_WINDOW
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Configuration and serial commands
    input  wire logic       step_write,
    input  wire logic [3:0] step_data,
    input  wire logic       cmd_valid,
    input  wire logic [3:0] cmd_code,
    input  wire logic       cmd_illegal,
    // Mode control
    input  wire logic       power_down,
    input  wire logic       modulation_active,
    input  wire logic       fast_start_request,
    // Analog comparators
    input  wire logic       overtemp_detect,
    input  wire logic       high_side_overcurrent,
    input  wire logic       low_side_overcurrent,
    input  wire logic       return_line_overcurrent,
    input  wire logic       boost_current_above_ref,
    input  wire logic       sense_resistor_input,
    // Power stage outputs
    output logic [3:0]      current_step_field,
    output logic            antenna_drive_output,
    output logic            boost_charge_switch,
    output logic            fast_start_switch,
    output logic            current_limit,
    output logic            lf_buffer_clear,
    // Status read
    output logic            status_valid,
    output logic [7:0]      status_data
);
    localparam int NSYNC = 6;

    function automatic logic [5:0] high_cycles(input logic [3:0] step);
        int q;
        q = antenna_diag_pkg::HIGH_Q_GROUP0;
        unique case (step[3:2])
            2'b00: q = antenna_diag_pkg::HIGH_Q_GROUP0;
            2'b01: q = antenna_diag_pkg::HIGH_Q_GROUP1;
            2'b10: q = antenna_diag_pkg::HIGH_Q_GROUP2;
            2'b11: q = antenna_diag_pkg::HIGH_Q_GROUP3;
        endcase
        high_cycles = 6'((q * antenna_diag_pkg::EIGHTH_CYCLES) / 4);
    endfunction : high_cycles

    // Two-flop synchronisers for the analog flags
    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= {sense_resistor_input, boost_current_above_ref, return_line_overcurrent,
                       low_side_overcurrent, high_side_overcurrent, overtemp_detect};
            sync_r <= meta_r;
        end
    end
    logic temp_s, hs_s, ls_s, ret_s, cmp_s, sense_s;
    assign {sense_s, cmp_s, ret_s, ls_s, hs_s, temp_s} = sync_r;

    // Operating state and diagnosis flags
    antenna_diag_pkg::op_state_e state_r, state_nxt;
    logic [5:0] flags_r, flags_nxt;
    logic [3:0] step_r, step_nxt;
    logic       clear_cmd, read_cmd, any_exp, watching, driving;
    logic       exp_temp, exp_gnd, exp_sup, exp_open, exp_ret;
    logic       open_cond;

    assign clear_cmd = cmd_valid && (cmd_code == antenna_diag_pkg::CMD_CLEAR_STATUS);
    assign read_cmd  = cmd_valid && (cmd_code == antenna_diag_pkg::CMD_READ_STATUS);
    assign any_exp   = exp_temp | exp_gnd | exp_sup | exp_open | exp_ret;
    assign watching  = (state_r == antenna_diag_pkg::ST_STANDBY) || (state_r == antenna_diag_pkg::ST_ACTIVE);
    assign driving   = (state_r == antenna_diag_pkg::ST_ACTIVE);

    always_comb
    begin
        state_nxt = state_r;
        flags_nxt = flags_r;
        step_nxt  = step_r;
        if (step_write)
        begin
            step_nxt = step_data;
        end
        unique case (state_r)
            antenna_diag_pkg::ST_OFF,
            antenna_diag_pkg::ST_STANDBY,
            antenna_diag_pkg::ST_ACTIVE:
            begin
                state_nxt = power_down        ? antenna_diag_pkg::ST_OFF    :
                            modulation_active ? antenna_diag_pkg::ST_ACTIVE :
                                                antenna_diag_pkg::ST_STANDBY;
                if (watching && any_exp)
                begin
                    state_nxt = antenna_diag_pkg::ST_SHUTDOWN;
                end
            end
            antenna_diag_pkg::ST_SHUTDOWN:
            begin
                if (clear_cmd)
                begin
                    state_nxt = antenna_diag_pkg::ST_STANDBY;
                end
            end
            default: state_nxt = antenna_diag_pkg::ST_OFF;
        endcase
        if (clear_cmd)
        begin
            flags_nxt = '0;
        end
        if (watching)
        begin
            flags_nxt[antenna_diag_pkg::BIT_TEMP] = flags_nxt[antenna_diag_pkg::BIT_TEMP] | exp_temp;
            flags_nxt[antenna_diag_pkg::BIT_GND] = flags_nxt[antenna_diag_pkg::BIT_GND] | exp_gnd;
            flags_nxt[antenna_diag_pkg::BIT_SUPPLY] = flags_nxt[antenna_diag_pkg::BIT_SUPPLY] | exp_sup;
            flags_nxt[antenna_diag_pkg::BIT_OPEN] = flags_nxt[antenna_diag_pkg::BIT_OPEN] | exp_open;
            flags_nxt[antenna_diag_pkg::BIT_RETURN] = flags_nxt[antenna_diag_pkg::BIT_RETURN] | exp_ret;
            flags_nxt[antenna_diag_pkg::BIT_BADCMD] = flags_nxt[antenna_diag_pkg::BIT_BADCMD] | cmd_illegal;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_r <= antenna_diag_pkg::ST_OFF;
            flags_r <= '0;
            step_r  <= antenna_diag_pkg::STEP_DEFAULT;
        end
        else
        begin
            state_r <= state_nxt;
            flags_r <= flags_nxt;
            step_r  <= step_nxt;
        end
    end

    fault_debounce #(.CYCLES(DEBOUNCE)) u_deb_temp (.clock(clock), .sys_rst(sys_rst),
        .enable(watching), .condition(temp_s), .expired(exp_temp));
    // Short to ground only when driving
    fault_debounce #(.CYCLES(DEBOUNCE)) u_deb_gnd (.clock(clock), .sys_rst(sys_rst),
        .enable(driving), .condition(hs_s), .expired(exp_gnd));
    fault_debounce #(.CYCLES(DEBOUNCE)) u_deb_sup (.clock(clock), .sys_rst(sys_rst),
        .enable(watching), .condition(ls_s), .expired(exp_sup));
    fault_debounce #(.CYCLES(DEBOUNCE)) u_deb_open (.clock(clock), .sys_rst(sys_rst),
        .enable(driving), .condition(open_cond), .expired(exp_open));
    fault_debounce #(.CYCLES(DEBOUNCE)) u_deb_ret (.clock(clock), .sys_rst(sys_rst),
        .enable(watching), .condition(ret_s), .expired(exp_ret));

    // Open-load watch: time since last polarity change
    localparam int OW = $clog2(OPEN_WIN + 1);
    logic [OW-1:0] quiet_r, quiet_nxt;
    logic          sense_d_r;
    always_comb
    begin
        quiet_nxt = (!driving || (sense_s != sense_d_r)) ? '0 :
                    (quiet_r != OW'(OPEN_WIN))          ? quiet_r + OW'(1) : quiet_r;
    end
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            quiet_r   <= '0;
            sense_d_r <= 1'b0;
        end
        else
        begin
            quiet_r   <= quiet_nxt;
            sense_d_r <= sense_s;
        end
    end
    assign open_cond = (quiet_r == OW'(OPEN_WIN));

    // Drive phase and boost period counters
    localparam int BW = $clog2(antenna_diag_pkg::BOOST_PERIOD);
    logic [5:0]    phase_r, phase_nxt;
    logic [BW-1:0] bper_r, bper_nxt;
    logic drv_r, drv_nxt, chg_r, chg_nxt, fs_r, fs_nxt, lim_r, lim_nxt, clr_r, clr_nxt;
    logic stages_on;
    assign stages_on = (state_r == antenna_diag_pkg::ST_ACTIVE) || (state_r == antenna_diag_pkg::ST_STANDBY);

    always_comb
    begin
        phase_nxt = phase_r + 6'h01;
        bper_nxt  = (bper_r == BW'(antenna_diag_pkg::BOOST_PERIOD - 1)) ? '0 : bper_r + BW'(1);
        // Duty from step group; pulses start at phase zero only, so no runt pulse
        drv_nxt   = driving && !any_exp && (phase_nxt < high_cycles(step_r)) && (drv_r || phase_nxt == 6'h00);
        chg_nxt   = stages_on && !any_exp && !cmp_s && (chg_r || bper_r == '0);
        fs_nxt  = stages_on && !any_exp && fast_start_request;
        lim_nxt = watching && (hs_s || ls_s);
        clr_nxt = watching && any_exp;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            phase_r <= '0;
            bper_r  <= '0;
            drv_r   <= 1'b0;
            chg_r   <= 1'b0;
            fs_r    <= 1'b0;
            lim_r   <= 1'b0;
            clr_r   <= 1'b0;
        end
        else
        begin
            phase_r <= phase_nxt;
            bper_r  <= bper_nxt;
            drv_r   <= drv_nxt;
            chg_r   <= chg_nxt;
            fs_r    <= fs_nxt;
            lim_r   <= lim_nxt;
            clr_r   <= clr_nxt;
        end
    end

    // Status read path
    logic       sv_r, sv_nxt;
    logic [7:0] sd_r, sd_nxt;
    always_comb
    begin
        sv_nxt = read_cmd;
        sd_nxt = read_cmd ? {2'b00, flags_r} : sd_r;
    end
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sv_r <= 1'b0;
            sd_r <= 8'h00;
        end
        else
        begin
            sv_r <= sv_nxt;
            sd_r <= sd_nxt;
        end
    end

    assign current_step_field   = step_r;
    assign antenna_drive_output = drv_r;
    assign boost_charge_switch  = chg_r;
    assign fast_start_switch    = fs_r;
    assign current_limit        = lim_r;
    assign lf_buffer_clear      = clr_r;
    assign status_valid         = sv_r;
    assign status_data          = sd_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_step_default;
        $fell(sys_rst) |-> step_r == 4'hF;
    endproperty
    a_step_default: assert property (p_step_default) else $error("step not 16 after reset");
    property p_shut_off;
        state_r == antenna_diag_pkg::ST_SHUTDOWN |-> !drv_r && !chg_r && !fs_r;
    endproperty
    a_shut_off: assert property (p_shut_off) else $error("stage on in shutdown");
    property p_buf_clear;
        watching && any_exp |=> lf_buffer_clear && state_r == antenna_diag_pkg::ST_SHUTDOWN;
    endproperty
    a_buf_clear: assert property (p_buf_clear) else $error("no buffer clear on fault");
    property p_read;
        read_cmd |=> status_valid && status_data == {2'b00, $past(flags_r)};
    endproperty
    a_read: assert property (p_read) else $error("status read wrong");
    property p_hold;
        state_r == antenna_diag_pkg::ST_SHUTDOWN && !clear_cmd |=> state_r == antenna_diag_pkg::ST_SHUTDOWN;
    endproperty
    a_hold: assert property (p_hold) else $error("left shutdown without clear");
    property p_sticky;
        !clear_cmd |=> (flags_r & $past(flags_r)) == $past(flags_r);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_illegal;
        cmd_illegal && watching && !any_exp && state_r == antenna_diag_pkg::ST_STANDBY
            |=> flags_r[antenna_diag_pkg::BIT_BADCMD] && !lf_buffer_clear && state_r != antenna_diag_pkg::ST_SHUTDOWN;
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal command handled wrong");
    property p_boost_off;
        cmp_s |=> !boost_charge_switch;
    endproperty
    a_boost_off: assert property (p_boost_off) else $error("charge switch on above reference");
    property p_pd_quiet;
        state_r == antenna_diag_pkg::ST_OFF |=> !lf_buffer_clear && !fast_start_switch;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("activity in power-down");
    property p_drive_rise;
        $rose(drv_r) |-> phase_r == 6'h00;
    endproperty
    a_drive_rise: assert property (p_drive_rise) else $error("drive edge off period start");
    property p_limit;
        watching && hs_s |=> current_limit;
    endproperty
    a_limit: assert property (p_limit) else $error("no current limit");

    c_shutdown: cover property (watching && any_exp);
    c_restart: cover property (state_r == antenna_diag_pkg::ST_SHUTDOWN && clear_cmd);
    c_read: cover property (read_cmd && flags_r != '0);
endmodule : antenna_fault_diag_current_select

// ---- verif/host_cmd_model.sv ----
// Host model: issues decoded serial commands and illegal-command strobes.
// Assumes every request is launched just after a rising edge of the shared clock.
module host_cmd_model
(
    // Clock
    input  wire logic  clock,
    // Decoded command strobes
    output logic       cmd_valid,
    output logic [3:0] cmd_code,
    output logic       cmd_illegal
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cmd_valid   = 1'b0;
        cmd_code    = 4'h0;
        cmd_illegal = 1'b0;
    end

    // one-cycle command pulse after an optional delay
    task automatic issue(input logic [3:0] code, input int gap);
        repeat (gap) @(posedge clock);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        @(posedge clock);
        cmd_valid <= 1'b0;
        // Idle code shows the inverse, so a stale code can never pass
        cmd_code  <= ~code;
    endtask : issue

    task automatic flag_illegal;
        @(posedge clock);
        cmd_illegal <= 1'b1;
        @(posedge clock);
        cmd_illegal <= 1'b0;
    endtask : flag_illegal
endmodule : host_cmd_model

// ---- verif/testbench.sv ----
// Self-checking bench for the antenna current select and fault diagnosis block.
// Assumes short debounce and open-load windows set by parameter for simulation.
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEB  = 8;
    localparam int OWIN = 16;

    logic       clock;
    logic       sys_rst;
    logic       step_write;
    logic [3:0] step_data;
    logic       power_down;
    logic       modulation_active;
    logic       fast_start_request;
    logic       overtemp_detect;
    logic       high_side_overcurrent;
    logic       low_side_overcurrent;
    logic       return_line_overcurrent;
    logic       boost_current_above_ref;
    logic       sense_resistor_input;
    logic       cmd_valid;
    logic [3:0] cmd_code;
    logic       cmd_illegal;
    logic [3:0] current_step_field;
    logic       antenna_drive_output;
    logic       boost_charge_switch;
    logic       fast_start_switch;
    logic       current_limit;
    logic       lf_buffer_clear;
    logic       status_valid;
    logic [7:0] status_data;
    bit         sense_en;
    int         n_mismatch;
    int         comparisons;
    int         cycles;
    int         clears;

    host_cmd_model i_host_cmd_model (.clock(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_illegal(cmd_illegal));

    antenna_fault_diag_current_select #(.DEBOUNCE(DEB), .OPEN_WIN(OWIN)) i_antenna_fault_diag_current_select (
        .clock(clock), .sys_rst(sys_rst), .step_write(step_write), .step_data(step_data),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_illegal(cmd_illegal),
        .power_down(power_down), .modulation_active(modulation_active),
        .fast_start_request(fast_start_request), .overtemp_detect(overtemp_detect),
        .high_side_overcurrent(high_side_overcurrent), .low_side_overcurrent(low_side_overcurrent),
        .return_line_overcurrent(return_line_overcurrent),
        .boost_current_above_ref(boost_current_above_ref), .sense_resistor_input(sense_resistor_input),
        .current_step_field(current_step_field), .antenna_drive_output(antenna_drive_output),
        .boost_charge_switch(boost_charge_switch), .fast_start_switch(fast_start_switch),
        .current_limit(current_limit), .lf_buffer_clear(lf_buffer_clear),
        .status_valid(status_valid), .status_data(status_data));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Cycle ceiling, buffer-clear pulse count and antenna sense polarity changes
    always @(posedge clock)
    begin
        cycles++;
        if (lf_buffer_clear === 1'b1)
            clears++;
        if (sense_en)
            sense_resistor_input <= cycles[2];
        if (cycles == 20000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    task automatic set_mode(input logic pd, input logic ma);
        @(posedge clock);
        power_down        <= pd;
        modulation_active <= ma;
        tick(3);
    endtask : set_mode

    task automatic set_faults(input logic [3:0] v);
        @(posedge clock);
        overtemp_detect         <= v[0];
        high_side_overcurrent   <= v[1];
        low_side_overcurrent    <= v[2];
        return_line_overcurrent <= v[3];
    endtask : set_faults

    task automatic read_status(input logic [7:0] exp);
        i_host_cmd_model.issue(antenna_diag_pkg::CMD_READ_STATUS, 0);
        @(negedge clock);
        `CHK(status_valid, 1'b1)
        `CHK(status_data, exp)
    endtask : read_status

    // Boost switch must start a charge period within 60 cycles, just over one boost period
    task automatic expect_boost_on;
        bit seen;
        seen = 1'b0;
        repeat (60) begin @(negedge clock); if (boost_charge_switch === 1'b1) seen = 1'b1; end
        `CHK(seen, 1'b1)
    endtask : expect_boost_on

    task automatic test_reset;
        `CHK(current_step_field, 4'hF)
        `CHK(lf_buffer_clear, 1'b0)
        read_status(8'h00);
    endtask : test_reset

    task automatic test_steps;
        int hi;
        int hq[4];
        hq = '{10, 14, 20, 32};
        sense_en = 1'b1;
        set_mode(1'b0, 1'b1);
        for (int s = 0; s < 16; s++)
        begin
            @(posedge clock);
            step_write <= 1'b1;
            step_data  <= 4'(s);
            @(posedge clock);
            step_write <= 1'b0;
            tick(70);
            hi = 0;
            repeat (128) begin @(negedge clock); hi += int'(antenna_drive_output === 1'b1); end
            `CHK(current_step_field, 4'(s))
            `CHK(hi, 2 * hq[s / 4])
        end
    endtask : test_steps

    // One debounced fault: f selects the source and equals its status bit
    task automatic fault_case(input int f);
        bit seen;
        seen = 1'b0;
        sense_en = (f != 3);
        set_mode(1'b0, (f == 1 || f == 3));
        if (f != 3)
            set_faults(4'(1 << ((f == 4) ? 3 : f)));
        if (f == 1 || f == 2)
        begin
            tick(4);
            @(negedge clock);
            `CHK(current_limit, 1'b1)
        end
        repeat (60) begin @(negedge clock); if (lf_buffer_clear === 1'b1 && !seen) seen = 1'b1; end
        `CHK(seen, 1'b1)
        `CHK(fast_start_switch, 1'b0)
        `CHK(antenna_drive_output, 1'b0)
        set_faults(4'h0);
        sense_en = 1'b1;
        set_mode(1'b0, 1'b0);
        tick(60);
        @(negedge clock);
        `CHK(boost_charge_switch, 1'b0)
        read_status(8'(1 << f));
        i_host_cmd_model.issue(antenna_diag_pkg::CMD_CLEAR_STATUS, 2);
        read_status(8'h00);
        expect_boost_on();
    endtask : fault_case

    task automatic test_glitch;
        int c0;
        set_mode(1'b0, 1'b0);
        c0 = clears;
        set_faults(4'h1);
        tick(4);
        set_faults(4'h0);
        tick(30);
        `CHK(clears, c0)
        read_status(8'h00);
    endtask : test_glitch

    task automatic test_gating;
        int c0;
        c0 = clears;
        set_mode(1'b1, 1'b0);
        set_faults(4'hF);
        tick(30);
        @(negedge clock);
        `CHK(fast_start_switch, 1'b0)
        set_faults(4'h0);
        read_status(8'h00);
        sense_en = 1'b0;
        set_mode(1'b0, 1'b0);
        set_faults(4'h2);
        tick(40);
        set_faults(4'h0);
        sense_en = 1'b1;
        `CHK(clears, c0)
        read_status(8'h00);
    endtask : test_gating

    task automatic test_illegal_and_boost;
        int c0;
        set_mode(1'b0, 1'b0);
        c0 = clears;
        i_host_cmd_model.flag_illegal();
        tick(2);
        read_status(8'h20);
        `CHK(clears, c0)
        expect_boost_on();
        i_host_cmd_model.issue(antenna_diag_pkg::CMD_CLEAR_STATUS, 0);
        read_status(8'h00);
        @(posedge clock);
        boost_current_above_ref <= 1'b1;
        tick(5);
        @(negedge clock);
        `CHK(boost_charge_switch, 1'b0)
        @(posedge clock);
        boost_current_above_ref <= 1'b0;
        expect_boost_on();
    endtask : test_illegal_and_boost

    task automatic give_verdict;
        $display("Mismatches %0d of %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    initial
    begin
        sys_rst = 1'b1;
        step_write = 1'b0;
        step_data = 4'h0;
        power_down = 1'b1;
        modulation_active = 1'b0;
        fast_start_request = 1'b1;
        overtemp_detect = 1'b0;
        high_side_overcurrent = 1'b0;
        low_side_overcurrent = 1'b0;
        return_line_overcurrent = 1'b0;
        boost_current_above_ref = 1'b0;
        sense_resistor_input = 1'b0;
        sense_en = 1'b0;
        tick(20);
        sys_rst <= 1'b0;
        @(negedge clock);
        test_reset();
        test_steps();
        for (int f = 0; f < 5; f++)
            fault_case(f);
        test_glitch();
        test_gating();
        test_illegal_and_boost();
        give_verdict();
    end
endmodule : testbench
